//--- logic/qdc_serial_load.sv
`timescale 1ns/10ps
`include "qdc_defines.svh"

module qdc_serial_load (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial link pins from the host
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  // Control pins
  input wire logic output_load_strobe_n,
  input wire logic register_preset_n,
  input wire logic preset_level,
  // Input rank contents
  output qdc_pkg::qdc_code_t input_code_a,
  output qdc_pkg::qdc_code_t input_code_b,
  output qdc_pkg::qdc_code_t input_code_c,
  output qdc_pkg::qdc_code_t input_code_d,
  // Output rank contents, feeding the converters
  output qdc_pkg::qdc_code_t dac_code_a,
  output qdc_pkg::qdc_code_t dac_code_b,
  output qdc_pkg::qdc_code_t dac_code_c,
  output qdc_pkg::qdc_code_t dac_code_d,
  // Preset currently forcing both ranks
  output logic preset_active
);

  // ************************************************************
  // Local types and helpers
  // ************************************************************

  // Width of the pin group passed through the synchroniser
  localparam int PINS = 6;

  // Preset word reduced to the code width (upper bits of the word)
  localparam qdc_pkg::qdc_code_t ZERO_CODE = 14'(`QDC_ZERO_WORD >> 2);
  localparam qdc_pkg::qdc_code_t HALF_CODE = 14'(`QDC_HALF_WORD >> 2);

  // One-hot channel decode of the two select bits
  function automatic logic [`QDC_CHANNELS-1:0] chan_decode(input logic [1:0] sel);
    logic [`QDC_CHANNELS-1:0] hot;
    hot = '0;
    case (qdc_pkg::qdc_chan_e'(sel))
      qdc_pkg::QDC_CHAN_A: hot = 4'h1;
      qdc_pkg::QDC_CHAN_B: hot = 4'h2;
      qdc_pkg::QDC_CHAN_C: hot = 4'h4;
      qdc_pkg::QDC_CHAN_D: hot = 4'h8;
      default: hot = 4'h0;
    endcase
    return hot;
  endfunction : chan_decode

  // ************************************************************
  // Pin synchronisation
  // ************************************************************

  // Raw and synchronised pin group
  logic [PINS-1:0] pins_raw;
  logic [PINS-1:0] pins_s;
  // Individual synchronised levels
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic output_load_strobe_n_n_s;
  logic preset_n_s;
  logic level_s;

  assign pins_raw = {preset_level, register_preset_n, output_load_strobe_n,
                     serial_in, chip_select_n, serial_clk};

  // Every pin is asynchronous to ref_clk, so all pass two flops
  qdc_sync #(
    .WIDTH(PINS),
    .IDLE(`QDC_PIN_IDLE)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign output_load_strobe_n_n_s = pins_s[3];
  assign preset_n_s = pins_s[4];
  assign level_s = pins_s[5];

  // ************************************************************
  // Serial link: edge finding and shift register
  // ************************************************************

  // Previous synchronised levels, for edge finding
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic cs_prev_q;
  logic cs_prev_d;
  // Serial shift register, newest bit at position 0
  logic [`QDC_FRAME_BITS-1:0] serial_shift_reg_q;
  logic [`QDC_FRAME_BITS-1:0] serial_shift_reg_d;
  // Edge strobes
  logic sclk_rise;
  logic cs_rise;

  // Next values of the link group
  always_comb begin
    sclk_rise = sclk_s & ~sclk_prev_q;
    cs_rise = cs_n_s & ~cs_prev_q;
    sclk_prev_d = sclk_s;
    cs_prev_d = cs_n_s;
    serial_shift_reg_d = serial_shift_reg_q;
    // Shift only on a clock rise with chip select low; older bits fall off the top
    if (!cs_n_s && sclk_rise) begin
      serial_shift_reg_d = {serial_shift_reg_q[`QDC_FRAME_BITS-2:0], sdi_s};
    end
  end

  // Link group registers; the shift register is never touched by the preset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      serial_shift_reg_q <= '0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
      serial_shift_reg_q <= serial_shift_reg_d;
    end
  end

  // ************************************************************
  // Register ranks and preset
  // ************************************************************

  // Frame fields as they stand when chip select rises
  logic [1:0] channel_select;
  logic channel_select_hi;
  logic channel_select_lo;
  qdc_pkg::qdc_code_t code_bits;
  logic [`QDC_CHANNELS-1:0] chan_hot;
  // Power-on preset window counter
  logic [1:0] por_cnt_q;
  logic [1:0] por_cnt_d;
  // Preset forcing, and the value it forces
  logic force_preset;
  qdc_pkg::qdc_code_t preset_code;
  // Input and output ranks
  qdc_pkg::qdc_code_t in_q [`QDC_CHANNELS];
  qdc_pkg::qdc_code_t in_d [`QDC_CHANNELS];
  qdc_pkg::qdc_code_t dac_q [`QDC_CHANNELS];
  qdc_pkg::qdc_code_t dac_d [`QDC_CHANNELS];
  // Registered preset flag for the status port
  logic preset_q;

  // Fields of the last 18 bits; bits 15 and 14 are ignored
  assign channel_select_hi = serial_shift_reg_q[`QDC_SEL_HI_POS];
  assign channel_select_lo = serial_shift_reg_q[`QDC_SEL_LO_POS];
  assign channel_select = {channel_select_hi, channel_select_lo};
  assign code_bits = serial_shift_reg_q[`QDC_CODE_MSB:0];
  assign chan_hot = chan_decode(channel_select);

  // Next values of the ranks; the preset outranks everything else
  always_comb begin
    force_preset = ~preset_n_s | (por_cnt_q != 2'h0);
    preset_code = level_s ? HALF_CODE : ZERO_CODE;
    por_cnt_d = (por_cnt_q != 2'h0) ? por_cnt_q - 2'h1 : 2'h0;
    for (int ch = 0; ch < `QDC_CHANNELS; ch++) begin
      in_d[ch] = in_q[ch];
      dac_d[ch] = dac_q[ch];
      if (force_preset) begin
        // Both ranks held at the preset value; writes are dropped
        in_d[ch] = preset_code;
        dac_d[ch] = preset_code;
      end else begin
        // Only the addressed channel takes the code
        if (cs_rise && chan_hot[ch]) begin
          in_d[ch] = code_bits;
        end
        // Strobe low follows the input rank; high (or its rise) holds
        if (!output_load_strobe_n_n_s) begin
          dac_d[ch] = in_q[ch];
        end
      end
    end
  end

  // Rank registers; reset clears them and the power-on window then applies the level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_q <= `QDC_POR_CYCLES;
      preset_q <= 1'b1;
      for (int ch = 0; ch < `QDC_CHANNELS; ch++) begin
        in_q[ch] <= '0;
        dac_q[ch] <= '0;
      end
    end else begin
      por_cnt_q <= por_cnt_d;
      preset_q <= force_preset;
      for (int ch = 0; ch < `QDC_CHANNELS; ch++) begin
        in_q[ch] <= in_d[ch];
        dac_q[ch] <= dac_d[ch];
      end
    end
  end

  // ************************************************************
  // Outputs, all straight from flip-flops
  // ************************************************************

  assign input_code_a = in_q[0];
  assign input_code_b = in_q[1];
  assign input_code_c = in_q[2];
  assign input_code_d = in_q[3];
  assign dac_code_a = dac_q[0];
  assign dac_code_b = dac_q[1];
  assign dac_code_c = dac_q[2];
  assign dac_code_d = dac_q[3];
  assign preset_active = preset_q;

endmodule : qdc_serial_load

//--- logic/qdc_sync.sv
`timescale 1ns/10ps

// ************************************************************
// Two-flop synchroniser for a group of pin levels
// ************************************************************
module qdc_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Raw pins
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised levels
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_q;
  // Second stage
  logic [WIDTH-1:0] sync_q;

  // Both stages reset to the idle pin levels so no false edge appears
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : qdc_sync

//--- pkg/qdc_defines.svh
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH

// ************************************************************
// Frame layout
// ************************************************************
// Bits kept from one chip-select low period
`define QDC_FRAME_BITS 18
// Upper channel-select bit position
`define QDC_SEL_HI_POS 17
// Lower channel-select bit position
`define QDC_SEL_LO_POS 16
// Code field, most significant bit position
`define QDC_CODE_MSB 13
// Code field width
`define QDC_CODE_BITS 14
// Number of channels
`define QDC_CHANNELS 4

// ************************************************************
// Preset values, as 16-bit words left aligned
// ************************************************************
// Zero code word
`define QDC_ZERO_WORD 16'h0000
// Half-scale word
`define QDC_HALF_WORD 16'h8000

// ************************************************************
// Pin sampling and power-on timing
// ************************************************************
// Idle levels of the synchronised pins after reset
`define QDC_PIN_IDLE 6'h1A
// Cycles the power-on preset is held after reset release
`define QDC_POR_CYCLES 2'h3

`endif

//--- pkg/qdc_pkg.sv
// ************************************************************
// Shared types of the serial load control
// ************************************************************
package qdc_pkg;

  // One channel code word
  typedef logic [13:0] qdc_code_t;

  // Channel numbering as carried in the select bits
  typedef enum logic [1:0] {
    QDC_CHAN_A = 2'h0,
    QDC_CHAN_B = 2'h1,
    QDC_CHAN_C = 2'h2,
    QDC_CHAN_D = 2'h3
  } qdc_chan_e;

endpackage : qdc_pkg

//--- verification/qdc_host.sv
`timescale 1ns/10ps

module qdc_host (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in
);
  // Idle link: clock parked low, select high
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Last n bits of f, MSB first, ph cycles per clock phase
  task automatic send(input logic [23:0] f, input int n, input int ph);
    @(posedge ref_clk) chip_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= f[i];
      repeat (ph) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (ph) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
    // Data released: show the inverse so stale bits cannot pass
    serial_in <= !f[0];
    repeat (ph) @(posedge ref_clk);
    chip_select_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : send
  // Clock pulses with select high; the device must not shift on them
  task automatic stray(input logic [23:0] f, input int n, input int ph);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk) serial_in <= f[i];
      repeat (ph) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (ph) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
  endtask : stray
endmodule : qdc_host

//--- verification/qdc_serial_load_asserts.sv
`timescale 1ns/10ps

module qdc_serial_load_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host and control pins
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic output_load_strobe_n,
  input wire logic register_preset_n,
  input wire logic preset_level,
  // Both ranks and the preset flag
  input wire qdc_pkg::qdc_code_t input_code_a,
  input wire qdc_pkg::qdc_code_t input_code_b,
  input wire qdc_pkg::qdc_code_t input_code_c,
  input wire qdc_pkg::qdc_code_t input_code_d,
  input wire qdc_pkg::qdc_code_t dac_code_a,
  input wire qdc_pkg::qdc_code_t dac_code_b,
  input wire qdc_pkg::qdc_code_t dac_code_c,
  input wire qdc_pkg::qdc_code_t dac_code_d,
  input wire logic preset_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Ranks flattened so one compare covers all channels
  wire logic [55:0] in_all = {input_code_a, input_code_b, input_code_c, input_code_d};
  wire logic [55:0] dac_all = {dac_code_a, dac_code_b, dac_code_c, dac_code_d};
  // Saturating run lengths of pin levels; they absorb the synchroniser lag
  logic [15:0] run_q, run_d;
  function automatic logic [3:0] run(input logic lvl, input logic [3:0] n);
    return !lvl ? 4'h0 : (n == 4'hF ? n : n + 4'h1);
  endfunction : run
  // Next run lengths
  always_comb begin
    run_d[3:0] = run(chip_select_n, run_q[3:0]);
    run_d[7:4] = run(output_load_strobe_n, run_q[7:4]);
    run_d[11:8] = run(!output_load_strobe_n, run_q[11:8]);
    run_d[15:12] = run(register_preset_n, run_q[15:12]);
  end
  // Run length registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= run_d;
    end
  end
  property p_preset_zero;
    (preset_active && !preset_level) [*6] |-> in_all == 56'h0 && dac_all == 56'h0;
  endproperty
  a_preset_zero: assert property (p_preset_zero)
    else $error("ranks not zero under preset");
  property p_preset_half;
    (preset_active && preset_level) [*6] |-> in_all == {4{14'h2000}} && dac_all == in_all;
  endproperty
  a_preset_half: assert property (p_preset_half)
    else $error("ranks not half scale under preset");
  property p_preset_enter;
    $fell(register_preset_n) |-> ##[1:4] preset_active;
  endproperty
  a_preset_enter: assert property (p_preset_enter)
    else $error("preset not taken");
  property p_preset_hold;
    !register_preset_n [*4] |-> preset_active;
  endproperty
  a_preset_hold: assert property (p_preset_hold)
    else $error("preset dropped while pin low");
  property p_preset_free;
    run_q[15:12] > 4'h7 |-> !preset_active;
  endproperty
  a_preset_free: assert property (p_preset_free)
    else $error("preset stuck after power-on window");
  property p_write_time;
    $changed(in_all) && !preset_active |-> run_q[3:0] inside {[2:5]};
  endproperty
  a_write_time: assert property (p_write_time)
    else $error("input rank changed away from select rise");
  property p_dac_hold;
    $changed(dac_all) && !preset_active |-> run_q[7:4] < 4'h5;
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("output rank moved with strobe high");
  property p_dac_follow;
    run_q[11:8] > 4'h3 && !preset_active |-> dac_all == $past(in_all);
  endproperty
  a_dac_follow: assert property (p_dac_follow)
    else $error("output rank not following");
  c_write: cover property ($changed(in_all) && !preset_active);
  c_half: cover property (preset_active && preset_level && !register_preset_n);
  c_follow: cover property (run_q[11:8] > 4'h3 && $changed(dac_all) && !preset_active);
endmodule : qdc_serial_load_asserts

bind qdc_serial_load qdc_serial_load_asserts i_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
  .chip_select_n(chip_select_n), .serial_in(serial_in),
  .output_load_strobe_n(output_load_strobe_n), .register_preset_n(register_preset_n),
  .preset_level(preset_level), .input_code_a(input_code_a), .input_code_b(input_code_b),
  .input_code_c(input_code_c), .input_code_d(input_code_d), .dac_code_a(dac_code_a),
  .dac_code_b(dac_code_b), .dac_code_c(dac_code_c), .dac_code_d(dac_code_d),
  .preset_active(preset_active));

//--- verification/quad_dac_serial_load_control_tb.sv
`timescale 1ns/10ps

module quad_dac_serial_load_control_tb;
  // Pins driven by the bench
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic output_load_strobe_n = 1'b1;
  logic register_preset_n = 1'b1;
  logic preset_level = 1'b1;
  wire logic serial_clk, chip_select_n, serial_in, preset_active;
  // Ranks as seen (0..3 input, 4..7 output) and as modelled
  wire qdc_pkg::qdc_code_t outs [8];
  qdc_pkg::qdc_code_t exp_q [8];
  logic exp_pa;
  int seed = 40;
  int compares = 0;
  int mismatches = 0;
  always #12.5 ref_clk = ~ref_clk;
  qdc_host i_host (.ref_clk(ref_clk), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in));
  qdc_serial_load i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .output_load_strobe_n(output_load_strobe_n), .register_preset_n(register_preset_n),
    .preset_level(preset_level), .input_code_a(outs[0]), .input_code_b(outs[1]),
    .input_code_c(outs[2]), .input_code_d(outs[3]), .dac_code_a(outs[4]),
    .dac_code_b(outs[5]), .dac_code_c(outs[6]), .dac_code_d(outs[7]),
    .preset_active(preset_active));
  task automatic chk(input string name, input qdc_pkg::qdc_code_t seen,
    input qdc_pkg::qdc_code_t want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask : chk
  // Settle past the write latency, then compare everything
  task automatic check_all();
    repeat (8) @(posedge ref_clk);
    // Look half a cycle after the edge, once the ranks have settled
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++) chk($sformatf("code%0d", i), outs[i], exp_q[i]);
    chk("preset_active", {13'h0, preset_active}, {13'h0, exp_pa});
  endtask : check_all
  // Random code to one channel, with garbage above the 18 kept bits
  task automatic frame(input int ch, input int n);
    qdc_pkg::qdc_code_t c;
    logic [23:0] f;
    c = 14'($random(seed));
    f = 24'($random(seed));
    f[17:0] = {ch[1:0], f[15:14], c};
    i_host.send(f, n, 4);
    if (register_preset_n) begin
      exp_q[ch] = c;
      if (!output_load_strobe_n) exp_q[ch + 4] = c;
    end
  endtask : frame
  task automatic strobe(input logic lvl);
    @(posedge ref_clk) output_load_strobe_n <= lvl;
    if (!lvl) for (int i = 0; i < 4; i++) exp_q[i + 4] = exp_q[i];
  endtask : strobe
  task automatic preset(input logic lvl);
    @(posedge ref_clk) preset_level <= lvl;
    repeat (4) @(posedge ref_clk);
    register_preset_n <= 1'b0;
    for (int i = 0; i < 8; i++) exp_q[i] = lvl ? 14'h2000 : 14'h0000;
    exp_pa = 1'b1;
    frame(($random(seed) & 3), 18);
    check_all();
    @(posedge ref_clk) register_preset_n <= 1'b1;
    exp_pa = 1'b0;
    check_all();
  endtask : preset
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    exp_q = '{default: 14'h2000};
    exp_pa = 1'b0;
    check_all();
    for (int i = 0; i < 4; i++) begin
      frame(i, 18 + 6 * (i % 2));
      check_all();
    end
    strobe(1'b0);
    check_all();
    frame(2, 24);
    check_all();
    // Stray clocks with select high, then an empty frame rewrites the same word
    i_host.stray(24'($random(seed)), 8, 4);
    i_host.send(24'h0, 0, 4);
    check_all();
    strobe(1'b1);
    frame(0, 18);
    check_all();
    preset(1'b0);
    preset(1'b1);
    strobe(1'b0);
    frame(3, 18);
    check_all();
    // Second reset with the level pin low: the power-on window gives zero code
    @(posedge ref_clk) sys_rst <= 1'b1;
    preset_level <= 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    exp_q = '{default: 14'h0000};
    check_all();
    frame(1, 18);
    check_all();
    summarize();
  end
endmodule : quad_dac_serial_load_control_tb
